// ### hw/caf_top.sv
// Receive acceptance filter: decides whether an assembled frame is stored.
// Assumes the protocol engine pulses frame_done once per valid frame.
//
// Operation
// - Decide storage for each assembled frame
// - Compare only after full valid reception
// - Matching frame loads filter's associated buffer
// - Mask ones select compared identifier bits
// - Mask zero positions always accept
// - Compared bits must equal; all must accept
// - Legacy: filters a,b, first mask, first buffer
// - Legacy: filters c-f, second mask, second buffer
// - FIFO mode: any enabled filter, next slot
`timescale 1ns/1ps
module caf_top
    import caf_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [1:0] op_mode,
    input wire logic [CAF_NUM_FILT-1:0] filt_enable,
    input wire logic cfg_we,
    input wire logic [3:0] cfg_sel,
    input wire logic [CAF_ID_W-1:0] cfg_data,
    input wire logic frame_done,
    input wire logic frame_valid,
    input wire logic frame_ext,
    input wire logic [CAF_ID_W-1:0] msg_assembly_buf_id,
    input wire logic slot_release,
    output logic load_req,
    output logic [1:0] load_target,
    output logic [CAF_PTR_W-1:0] load_slot,
    output logic [2:0] load_filter,
    output logic [CAF_PTR_W:0] fifo_count
);

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        caf_state_t state;
        logic [CAF_ID_W-1:0] id;
        logic ext;
        logic load;
        caf_tgt_t tgt;
        logic [CAF_PTR_W-1:0] wr_ptr;
        logic [CAF_PTR_W:0] count;
        logic [2:0] filt;
    } caf_top_st_t;

    caf_top_st_t st_r;
    caf_top_st_t st_nxt;
    logic [CAF_NUM_FILT-1:0] hit;
    logic [CAF_NUM_FILT-1:0] en_eff;
    logic hit_first;
    logic hit_second;
    logic fifo_full;
    logic [2:0] first_idx;
    logic is_fifo;

    assign is_fifo = (op_mode == CAF_MODE_FIFO);
    // Legacy modes use all six filters; fifo uses only enabled ones
    assign en_eff = is_fifo ? filt_enable : {CAF_NUM_FILT{1'b1}};

    caf_bank u_bank (
        .sys_clk(sys_clk),
        .rst(rst),
        .cfg_we(cfg_we),
        .cfg_sel(cfg_sel),
        .cfg_data(cfg_data),
        .cmp_id(st_r.id),
        .cmp_ext(st_r.ext),
        .filt_en(en_eff),
        .fifo_mode(is_fifo),
        .filt_hit(hit)
    );

    assign hit_first = |hit[CAF_GRP_FIRST_HI:CAF_GRP_FIRST_LO];
    assign hit_second = |hit[CAF_GRP_SECOND_HI:CAF_GRP_SECOND_LO];
    assign fifo_full = (st_r.count == (CAF_PTR_W + 1)'(CAF_FIFO_DEPTH));

    // Lowest numbered hitting filter
    always_comb begin
        first_idx = 3'h0;
        for (int i = CAF_NUM_FILT - 1; i >= 0; i--) begin
            if (hit[i]) begin
                first_idx = 3'(i);
            end
        end
    end

    // ****************************************************************
    // Sequencer
    // ****************************************************************
    always_comb begin
        st_nxt = st_r;
        st_nxt.load = 1'b0;
        if (slot_release && st_r.count != '0) begin
            st_nxt.count = st_r.count - 1'b1;
        end
        unique case (st_r.state)
            CAF_ST_IDLE: begin
                if (frame_done && frame_valid) begin
                    st_nxt.id = msg_assembly_buf_id;
                    st_nxt.ext = frame_ext;
                    st_nxt.state = CAF_ST_CMP;
                end
            end
            CAF_ST_CMP: begin
                st_nxt.state = CAF_ST_IDLE;
                st_nxt.filt = first_idx;
                st_nxt.tgt = CAF_TGT_NONE;
                if (is_fifo) begin
                    if ((|hit) && !fifo_full) begin
                        st_nxt.tgt = CAF_TGT_FIFO;
                        st_nxt.load = 1'b1;
                        st_nxt.wr_ptr = st_r.wr_ptr + 1'b1;
                        st_nxt.count = st_nxt.count + 1'b1;
                    end
                end else if (hit_first) begin
                    st_nxt.tgt = CAF_TGT_FIRST;
                    st_nxt.load = 1'b1;
                end else if (hit_second) begin
                    st_nxt.tgt = CAF_TGT_SECOND;
                    st_nxt.load = 1'b1;
                end
                if (st_nxt.load) begin
                    st_nxt.state = CAF_ST_LOAD;
                end
            end
            CAF_ST_LOAD: begin
                st_nxt.state = CAF_ST_IDLE;
            end
            default: begin
                st_nxt.state = CAF_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            st_r <= '0;
            st_r.state <= CAF_ST_IDLE;
            st_r.tgt <= CAF_TGT_NONE;
            st_r.wr_ptr <= CAF_PTR_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign load_req = st_r.load;
    assign load_target = st_r.tgt;
    assign load_slot = st_r.wr_ptr - 1'b1;
    assign load_filter = st_r.filt;
    assign fifo_count = st_r.count;

    // ****************************************************************
    // Checks
    // ****************************************************************
    start_after_done_a: assert property (@(posedge sys_clk) disable iff (rst)
        (st_r.state == CAF_ST_CMP) |-> $past(frame_done && frame_valid))
        else $error("Compare began without a finished frame");

    id_held_a: assert property (@(posedge sys_clk) disable iff (rst)
        (st_r.state != CAF_ST_IDLE) |=> $stable(st_r.id))
        else $error("Identifier changed during a decision");

    no_hit_no_load_a: assert property (@(posedge sys_clk) disable iff (rst)
        (st_r.state == CAF_ST_CMP && hit == '0) |=> !load_req)
        else $error("Frame loaded with no filter hit");

    no_hit_target_a: assert property (@(posedge sys_clk) disable iff (rst)
        (st_r.state == CAF_ST_CMP && hit == '0) |=> (load_target == CAF_TGT_NONE))
        else $error("Rejected frame left a buffer target");

    legacy_first_a: assert property (@(posedge sys_clk) disable iff (rst)
        (st_r.state == CAF_ST_CMP && !is_fifo && hit_first) |=>
        (load_req && load_target == CAF_TGT_FIRST))
        else $error("First group hit not sent to first buffer");

    legacy_second_a: assert property (@(posedge sys_clk) disable iff (rst)
        (st_r.state == CAF_ST_CMP && !is_fifo && !hit_first && hit_second) |=>
        (load_req && load_target == CAF_TGT_SECOND))
        else $error("Second group hit not sent to second buffer");

    load_has_target_a: assert property (@(posedge sys_clk) disable iff (rst)
        load_req |-> (load_target != CAF_TGT_NONE))
        else $error("Load raised with no buffer target");

    fifo_advance_a: assert property (@(posedge sys_clk) disable iff (rst)
        (load_req && load_target == CAF_TGT_FIFO) |->
        (st_r.wr_ptr == $past(st_r.wr_ptr) + 3'h1))
        else $error("Fifo pointer did not advance");

    fifo_accept_a: assert property (@(posedge sys_clk) disable iff (rst)
        (st_r.state == CAF_ST_CMP && is_fifo && hit != '0 && !fifo_full) |=>
        (load_req && load_target == CAF_TGT_FIFO))
        else $error("Fifo hit with free slot not loaded");

    fifo_full_drop_a: assert property (@(posedge sys_clk) disable iff (rst)
        (st_r.state == CAF_ST_CMP && is_fifo && fifo_full) |=> !load_req)
        else $error("Frame loaded into a full fifo");

    fifo_count_max_a: assert property (@(posedge sys_clk) disable iff (rst)
        (st_r.count <= (CAF_PTR_W + 1)'(CAF_FIFO_DEPTH)))
        else $error("Fifo count above depth");

    load_pulse_a: assert property (@(posedge sys_clk) disable iff (rst)
        load_req |=> !load_req)
        else $error("Load held longer than one cycle");

    mask_zero_a: assert property (@(posedge sys_clk) disable iff (rst)
        (caf_match(st_r.id, ~st_r.id, '0, st_r.ext)))
        else $error("Zero mask rejected a bit");

    full_compare_a: assert property (@(posedge sys_clk) disable iff (rst)
        (st_r.ext |-> !caf_match(st_r.id, st_r.id ^ 29'h10000000, '1, 1'b1)))
        else $error("Top extended bit not compared");

endmodule // caf_top

// ### hw/caf_pkg.sv
// Package for the receive acceptance filter: widths, modes, counts, resets.
// Assumes one 200 MHz clock shared by all users of these constants.
package caf_pkg;

    // ****************************************************************
    // Widths and counts
    // ****************************************************************
    localparam int CAF_ID_W = 29;
    localparam int CAF_STD_W = 11;
    localparam int CAF_NUM_FILT = 6;
    localparam int CAF_FIFO_DEPTH = 8;
    localparam int CAF_PTR_W = 3;

    // ****************************************************************
    // Legacy grouping of filters onto masks and buffers
    // ****************************************************************
    localparam int CAF_GRP_FIRST_LO = 0;
    localparam int CAF_GRP_FIRST_HI = 1;
    localparam int CAF_GRP_SECOND_LO = 2;
    localparam int CAF_GRP_SECOND_HI = 5;

    // ****************************************************************
    // Reset values
    // ****************************************************************
    localparam logic [CAF_ID_W-1:0] CAF_FILT_RST = 29'h0000000;
    localparam logic [CAF_ID_W-1:0] CAF_MASK_RST = 29'h0000000;
    localparam logic [CAF_NUM_FILT-1:0] CAF_FEN_RST = 6'h3f;
    localparam logic [CAF_PTR_W-1:0] CAF_PTR_RST = 3'h0;

    // ****************************************************************
    // Operating modes and buffer targets
    // ****************************************************************
    typedef enum logic [1:0] {
        CAF_MODE_LEGACY = 2'b00,
        CAF_MODE_ENH = 2'b01,
        CAF_MODE_FIFO = 2'b10
    } caf_mode_t;

    typedef enum logic [1:0] {
        CAF_TGT_NONE = 2'b00,
        CAF_TGT_FIRST = 2'b01,
        CAF_TGT_SECOND = 2'b10,
        CAF_TGT_FIFO = 2'b11
    } caf_tgt_t;

    typedef enum logic [1:0] {
        CAF_ST_IDLE = 2'b00,
        CAF_ST_CMP = 2'b01,
        CAF_ST_LOAD = 2'b10
    } caf_state_t;

    // Masked compare: zero mask bits accept, others need equality (low 11 bits only for standard frames)
    function automatic logic caf_match(input logic [CAF_ID_W-1:0] id,
                                       input logic [CAF_ID_W-1:0] filt,
                                       input logic [CAF_ID_W-1:0] mask,
                                       input logic ext);
        logic [CAF_ID_W-1:0] diff;
        logic [CAF_ID_W-1:0] used;
        diff = (id ^ filt) & mask;
        used = ext ? {CAF_ID_W{1'b1}} : {{(CAF_ID_W-CAF_STD_W){1'b0}}, {CAF_STD_W{1'b1}}};
        return ((diff & used) == '0);
    endfunction

endpackage

// ### hw/caf_bank.sv
// Holds the six filters and two masks and evaluates all filter hits.
// Assumes configuration writes come from the controller's own logic.
`timescale 1ns/1ps
module caf_bank
    import caf_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic cfg_we,
    input wire logic [3:0] cfg_sel,
    input wire logic [CAF_ID_W-1:0] cfg_data,
    input wire logic [CAF_ID_W-1:0] cmp_id,
    input wire logic cmp_ext,
    input wire logic [CAF_NUM_FILT-1:0] filt_en,
    input wire logic fifo_mode,
    output logic [CAF_NUM_FILT-1:0] filt_hit
);

    // ****************************************************************
    // Storage
    // ****************************************************************
    typedef struct packed {
        logic [CAF_NUM_FILT-1:0][CAF_ID_W-1:0] filt;
        logic [1:0][CAF_ID_W-1:0] mask;
    } caf_bank_st_t;

    caf_bank_st_t st_r;
    caf_bank_st_t st_nxt;

    always_comb begin
        st_nxt = st_r;
        if (cfg_we) begin
            if (cfg_sel < 4'(CAF_NUM_FILT)) begin
                st_nxt.filt[cfg_sel[2:0]] = cfg_data;
            end else if (cfg_sel < 4'(CAF_NUM_FILT + 2)) begin
                st_nxt.mask[cfg_sel[0]] = cfg_data;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            st_r.filt <= {CAF_NUM_FILT{CAF_FILT_RST}};
            st_r.mask <= {2{CAF_MASK_RST}};
        end else begin
            st_r <= st_nxt;
        end
    end

    // ****************************************************************
    // Hit evaluation
    // ****************************************************************
    always_comb begin
        for (int i = 0; i < CAF_NUM_FILT; i++) begin
            // Filters a,b use first mask; c..f use second
            filt_hit[i] = filt_en[i] & caf_match(cmp_id, st_r.filt[i],
                st_r.mask[(i > CAF_GRP_FIRST_HI) ? 1 : 0], cmp_ext);
        end
    end

    legacy_all_en_a: assert property (@(posedge sys_clk) disable iff (rst)
        !fifo_mode |-> (filt_en == '1)) else $error("Legacy mode dropped a filter");

endmodule // caf_bank

// ### tb/caf_engine_model.sv
// Stand-in for the protocol engine: hands assembled frames to the filter.
// Assumes one caller at a time and frames spaced by the send task itself.
`timescale 1ns/1ps
module caf_engine_model
    import caf_pkg::*;
(
    input wire logic sys_clk,
    output logic frame_done,
    output logic frame_valid,
    output logic frame_ext,
    output logic [CAF_ID_W-1:0] frame_id
);
    initial begin
        frame_done = 1'b0;
        frame_valid = 1'b0;
        frame_ext = 1'b0;
        frame_id = '0;
    end

    // One frame, then wait until the decision has landed
    task automatic send(input logic [CAF_ID_W-1:0] id, input logic ext, input logic ok);
        @(posedge sys_clk);
        #1;
        frame_done = 1'b1;
        frame_valid = ok;
        frame_ext = ext;
        frame_id = id;
        @(posedge sys_clk);
        #1;
        frame_done = 1'b0;
        frame_valid = ~ok;
        frame_ext = ~ext;
        frame_id = ~id;
        @(posedge sys_clk);
        #1;
    endtask
endmodule // caf_engine_model

// ### tb/testbench.sv
// Self-checking bench for the receive acceptance filter.
// Assumes the engine model drives the frame inputs.
`timescale 1ns/1ps
module testbench
    import caf_pkg::*;
();
    logic sys_clk, rst, cfg_we, frame_done, frame_valid, frame_ext, slot_release, load_req;
    logic [1:0] op_mode, load_target;
    logic [5:0] filt_enable;
    logic [3:0] cfg_sel, fifo_count;
    logic [CAF_ID_W-1:0] cfg_data, frame_id;
    logic [2:0] load_slot, load_filter;
    int num_errors = 0;
    int n_checks = 0;

    caf_engine_model eng (.sys_clk(sys_clk), .frame_done(frame_done),
        .frame_valid(frame_valid), .frame_ext(frame_ext), .frame_id(frame_id));
    caf_top DUT (.sys_clk(sys_clk), .rst(rst), .op_mode(op_mode), .filt_enable(filt_enable),
        .cfg_we(cfg_we), .cfg_sel(cfg_sel), .cfg_data(cfg_data), .frame_done(frame_done),
        .frame_valid(frame_valid), .frame_ext(frame_ext), .msg_assembly_buf_id(frame_id),
        .slot_release(slot_release), .load_req(load_req), .load_target(load_target),
        .load_slot(load_slot), .load_filter(load_filter), .fifo_count(fifo_count));

    // ****************************************************************
    // Helpers
    // ****************************************************************
    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic frame_chk(input logic [CAF_ID_W-1:0] id, input logic ext, input logic ok,
                             input logic req, input logic [1:0] tgt, input logic [2:0] filt);
        eng.send(id, ext, ok);
        chk_val({31'h0, load_req}, {31'h0, req});
        if (req) begin
            chk_val({30'h0, load_target}, {30'h0, tgt});
            chk_val({29'h0, load_filter}, {29'h0, filt});
        end
    endtask

    task automatic cfg(input logic [3:0] sel, input logic [CAF_ID_W-1:0] d);
        @(posedge sys_clk);
        #1;
        cfg_we = 1'b1;
        cfg_sel = sel;
        cfg_data = d;
        @(posedge sys_clk);
        #1;
        cfg_we = 1'b0;
        cfg_data = ~d;
    endtask

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_reset();
        chk_val({31'h0, load_req}, 32'h0);
        chk_val({28'h0, fifo_count}, 32'h0);
        chk_val({29'h0, load_slot}, 32'h7);
        frame_chk(29'h1abcdef, 1'b1, 1'b1, 1'b1, CAF_TGT_FIRST, 3'h0);
    endtask

    task automatic t_legacy();
        filt_enable = 6'h00;
        cfg(4'h0, 29'h123);
        cfg(4'h1, 29'h456);
        cfg(4'h2, 29'h0a0);
        cfg(4'h3, 29'h15555550);
        cfg(4'h4, 29'h300);
        cfg(4'h5, 29'h7f0);
        cfg(4'h6, 29'h7ff);
        cfg(4'h7, 29'h1ffffff0);
        cfg(4'h8, 29'h0);
        frame_chk(29'h123, 1'b0, 1'b1, 1'b1, CAF_TGT_FIRST, 3'h0);
        frame_chk(29'h456, 1'b0, 1'b1, 1'b1, CAF_TGT_FIRST, 3'h1);
        frame_chk(29'h0a5, 1'b0, 1'b1, 1'b1, CAF_TGT_SECOND, 3'h2);
        frame_chk(29'h15555553, 1'b1, 1'b1, 1'b1, CAF_TGT_SECOND, 3'h3);
        frame_chk(29'h553, 1'b0, 1'b1, 1'b1, CAF_TGT_SECOND, 3'h3);
        frame_chk(29'h05555553, 1'b1, 1'b1, 1'b0, CAF_TGT_NONE, 3'h0);
        chk_val({30'h0, load_target}, 32'h0);
        frame_chk(29'h124, 1'b0, 1'b1, 1'b0, CAF_TGT_NONE, 3'h0);
        chk_val({30'h0, load_target}, 32'h0);
        frame_chk(29'h123, 1'b0, 1'b0, 1'b0, CAF_TGT_NONE, 3'h0);
        op_mode = 2'h1;
        frame_chk(29'h456, 1'b0, 1'b1, 1'b1, CAF_TGT_FIRST, 3'h1);
    endtask

    task automatic t_fifo();
        op_mode = 2'h2;
        filt_enable = 6'h20;
        frame_chk(29'h123, 1'b0, 1'b1, 1'b0, CAF_TGT_NONE, 3'h0);
        for (int i = 0; i < 8; i++) begin
            frame_chk(29'h7f3, 1'b0, 1'b1, 1'b1, CAF_TGT_FIFO, 3'h5);
            chk_val({29'h0, load_slot}, i);
            chk_val({28'h0, fifo_count}, i + 1);
        end
        frame_chk(29'h7f3, 1'b0, 1'b1, 1'b0, CAF_TGT_NONE, 3'h0);
        chk_val({28'h0, fifo_count}, 32'h8);
        @(posedge sys_clk);
        #1;
        slot_release = 1'b1;
        @(posedge sys_clk);
        #1;
        slot_release = 1'b0;
        chk_val({28'h0, fifo_count}, 32'h7);
        frame_chk(29'h7f3, 1'b0, 1'b1, 1'b1, CAF_TGT_FIFO, 3'h5);
        chk_val({29'h0, load_slot}, 32'h0);
        chk_val({28'h0, fifo_count}, 32'h8);
    endtask

    // ****************************************************************
    // Run control
    // ****************************************************************
    task automatic tally_and_finish();
        $display("checks=%0d errors=%0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    initial begin
        #10000;
        num_errors++;
        tally_and_finish();
    end

    initial begin
        rst = 1'b1;
        op_mode = 2'h0;
        filt_enable = 6'h3f;
        cfg_we = 1'b0;
        cfg_sel = 4'h0;
        cfg_data = '0;
        slot_release = 1'b0;
        repeat (5) @(posedge sys_clk);
        #1;
        rst = 1'b0;
        t_reset();
        t_legacy();
        t_fifo();
        tally_and_finish();
    end
endmodule // testbench
